// [verilog/refsel_pkg.sv]
// package for the reference input selector: register map, fields, states
// assumes a 32-bit axi4-lite slave on a single 100 MHz clock
package refsel_pkg;

   // ----------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] MONITOR_OFFSET = 8'h04;
   localparam logic [7:0] HOLDOFF_OFFSET = 8'h08;
   localparam logic [7:0] STATUS_OFFSET = 8'h0C;
   localparam logic [7:0] STICKY_OFFSET = 8'h10;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CTRL_MODE_POS = 0;
   localparam int CTRL_MANUAL_POS = 2;
   localparam int CTRL_PRIO0_POS = 4;
   localparam int CTRL_PRIO1_POS = 6;
   localparam int CTRL_REVERT_POS = 8;
   localparam int CTRL_BLOCK_POS = 9;
   localparam int CTRL_MVPD_POS = 10;
   localparam int CTRL_BYPASS_POS = 11;
   localparam int MON_DIV_POS = 0;
   localparam int MON_REVALIDATION_COUNT_POS = 16;
   localparam int HOLD_START_POS = 0;
   localparam int HOLD_PRESCALE_POS = 8;
   localparam int STAT_VALID_POS = 0;
   localparam int STAT_SEL_POS = 2;
   localparam int STAT_REF_POS = 3;
   localparam int STAT_HOLD_POS = 4;
   localparam int STAT_COUNT_POS = 8;
   localparam int STICKY_INPUT_POS = 0;
   localparam int STICKY_REF_POS = 2;

   // ----------------------------------------
   // reset values and timing counts
   // ----------------------------------------
   localparam logic [11:0] CTRL_RESET = 12'h0F0;
   localparam logic [8:0] MON_DIV_RESET = 9'h00A;
   localparam logic [7:0] REVALIDATION_COUNT_RESET = 8'h08;
   localparam logic [7:0] HOLD_START_RESET = 8'hFF;
   localparam logic [23:0] HOLD_PRESCALE_RESET = 24'h00_1000;
   localparam logic [1:0] MISSING_EDGES = 2'h3;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      MODE_MANUAL = 2'b00,
      MODE_AUTO = 2'b01,
      MODE_SHORT_HOLD = 2'b10,
      MODE_AUTO_HOLD = 2'b11
   } selection_mode_t;

   typedef enum logic [1:0] {
      SEL_LOCKED = 2'b00,
      SEL_UNLOCKED = 2'b01,
      SEL_HOLDOVER = 2'b10
   } sel_state_t;

   typedef struct packed {
      logic first_pll_bypass;
      logic monitor_divider_powerdown;
      logic loss_report_block;
      logic revertive_enable;
      logic [1:0] priority1;
      logic [1:0] priority0;
      logic [1:0] manual_select;
      selection_mode_t selection_mode;
   } ctrl_t;

   typedef struct packed {
      logic holdover;
      logic reference_ok;
      logic active_select;
   } sel_out_t;

endpackage

// [verilog/reference_input_selector.sv]
// reference input activity monitors, selection state machine, hold-off counter
// assumes axi4-lite master on i_sys_clk; reference and vco-divided clocks are pins
// ----------------------------------------
// Function
// ----------------------------------------
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
module reference_input_selector (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic [1:0] i_ref_clk,
   input wire logic i_vco_clk,
   input wire logic i_vcxo_clk,
   input wire logic [31:0] i_phase_word,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic o_active_select,
   output logic o_holdover,
   output logic o_reference_ok,
   output logic [31:0] o_phase_word
);

   // ----------------------------------------
   // registers
   // ----------------------------------------
   refsel_pkg::ctrl_t ctrl_q;
   logic [8:0] mon_div_q;
   logic [7:0] revalidation_count_q;
   logic [7:0] hold_start_q;
   logic [23:0] hold_prescale_q;
   logic [1:0] sticky_input_q;
   logic sticky_ref_q;
   logic [1:0] loss_armed_q;
   refsel_pkg::sel_state_t state_q;
   logic sel_q;
   logic [31:0] held_word_q;

   // ----------------------------------------
   // pin synchronisers and edge detection
   // ----------------------------------------
   // every pin-sourced level goes through two flops before use
   logic [1:0] ref_s1_q, ref_s2_q, ref_s3_q;
   logic vco_s1_q, vco_s2_q, vco_s3_q;
   logic vcxo_s1_q, vcxo_s2_q, vcxo_s3_q;

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         ref_s1_q <= 2'h0;
         ref_s2_q <= 2'h0;
         ref_s3_q <= 2'h0;
         vco_s1_q <= 1'b0;
         vco_s2_q <= 1'b0;
         vco_s3_q <= 1'b0;
         vcxo_s1_q <= 1'b0;
         vcxo_s2_q <= 1'b0;
         vcxo_s3_q <= 1'b0;
      end else begin
         ref_s1_q <= i_ref_clk;
         ref_s2_q <= ref_s1_q;
         ref_s3_q <= ref_s2_q;
         vco_s1_q <= i_vco_clk;
         vco_s2_q <= vco_s1_q;
         vco_s3_q <= vco_s2_q;
         vcxo_s1_q <= i_vcxo_clk;
         vcxo_s2_q <= vcxo_s1_q;
         vcxo_s3_q <= vcxo_s2_q;
      end
   end

   logic [1:0] ref_rise;
   logic vco_rise;
   logic vcxo_rise;
   assign ref_rise = ref_s2_q & ~ref_s3_q;
   assign vco_rise = vco_s2_q & ~vco_s3_q;
   assign vcxo_rise = vcxo_s2_q & ~vcxo_s3_q;

   // ----------------------------------------
   // monitor reference divider
   // ----------------------------------------
   logic [8:0] mdiv_q;
   logic mon_tick;
   assign mon_tick = vco_rise && (mdiv_q == 9'h000) && !ctrl_q.monitor_divider_powerdown;

   always_ff @(posedge i_sys_clk) begin
      if (i_reset || ctrl_q.monitor_divider_powerdown) begin
         mdiv_q <= 9'h000;
      end else if (vco_rise) begin
         mdiv_q <= (mdiv_q == 9'h000) ? mon_div_q - 9'h001 : mdiv_q - 9'h001;
      end
   end

   // ----------------------------------------
   // per-input loss and revalidation monitors
   // ----------------------------------------
   logic [1:0] valid_q;
   logic [1:0] loss_event;
   logic [1:0] reval_event;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_mon
         logic [1:0] miss_q;
         logic seen_q;
         logic [7:0] good_q;
         always_ff @(posedge i_sys_clk) begin
            if (i_reset) begin
               miss_q <= 2'h0;
               seen_q <= 1'b0;
               good_q <= 8'h00;
               valid_q[gi] <= 1'b0;
            end else begin
               if (ref_rise[gi]) begin
                  seen_q <= 1'b1;
               end else if (mon_tick) begin
                  seen_q <= 1'b0;
               end
               if (mon_tick) begin
                  if (seen_q || ref_rise[gi]) begin
                     miss_q <= 2'h0;
                  end else if (miss_q != refsel_pkg::MISSING_EDGES) begin
                     miss_q <= miss_q + 2'h1;
                  end
               end
               if (mon_tick && !seen_q && !ref_rise[gi]
                   && miss_q == refsel_pkg::MISSING_EDGES - 2'h1) begin
                  valid_q[gi] <= 1'b0;
                  good_q <= 8'h00;
               end else if (!valid_q[gi] && ref_rise[gi]) begin
                  // counting consecutive periods; a third missed monitor tick in a row above restarts it
                  if (good_q + 8'h01 >= revalidation_count_q) begin
                     valid_q[gi] <= 1'b1;
                     good_q <= 8'h00;
                  end else begin
                     good_q <= good_q + 8'h01;
                  end
               end
            end
         end
         assign loss_event[gi] = mon_tick && !seen_q && !ref_rise[gi] && valid_q[gi]
            && miss_q == refsel_pkg::MISSING_EDGES - 2'h1;
         assign reval_event[gi] = !valid_q[gi] && ref_rise[gi] && (good_q + 8'h01 >= revalidation_count_q);
      end
   endgenerate

   // ----------------------------------------
   // priority choice
   // ----------------------------------------
   // ties go to input 0; returns the best valid input
   function automatic logic best_input(input logic [1:0] valid, input logic [1:0] p0,
                                       input logic [1:0] p1);
      if (valid == 2'b10) begin
         best_input = 1'b1;
      end else if (valid == 2'b11) begin
         best_input = (p1 > p0);
      end else begin
         best_input = 1'b0;
      end
   endfunction

   logic prio_pick;
   logic any_valid;
   logic [1:0] sel_prio, oth_prio;
   assign prio_pick = best_input(valid_q, ctrl_q.priority0, ctrl_q.priority1);
   assign any_valid = |valid_q;
   assign sel_prio = sel_q ? ctrl_q.priority1 : ctrl_q.priority0;
   assign oth_prio = sel_q ? ctrl_q.priority0 : ctrl_q.priority1;

   // ----------------------------------------
   // hold-off prescaler and counter
   // ----------------------------------------
   logic [23:0] pre_q;
   logic [7:0] hold_cnt_q;
   logic hold_run;
   logic hold_tick;
   logic hold_expire;
   assign hold_run = (ctrl_q.selection_mode == refsel_pkg::MODE_AUTO_HOLD)
      && (state_q == refsel_pkg::SEL_HOLDOVER);
   assign hold_tick = hold_run && vcxo_rise && (pre_q == 24'h00_0000);
   assign hold_expire = hold_tick && (hold_cnt_q <= 8'h01);

   always_ff @(posedge i_sys_clk) begin
      if (i_reset || !hold_run) begin
         pre_q <= hold_prescale_q;
         hold_cnt_q <= hold_start_q;
      end else if (vcxo_rise) begin
         pre_q <= (pre_q == 24'h00_0000) ? hold_prescale_q : pre_q - 24'h00_0001;
         if (hold_expire) begin
            hold_cnt_q <= hold_start_q;
         end else if (hold_tick) begin
            hold_cnt_q <= hold_cnt_q - 8'h01;
         end
      end
   end

   // ----------------------------------------
   // selection state machine
   // ----------------------------------------
   logic sel_loss;
   assign sel_loss = loss_event[sel_q] || !valid_q[sel_q];

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         state_q <= refsel_pkg::SEL_UNLOCKED;
         sel_q <= 1'b0;
      end else begin
         unique case (ctrl_q.selection_mode)
            refsel_pkg::MODE_MANUAL: begin
               sel_q <= ctrl_q.manual_select[0];
               state_q <= valid_q[ctrl_q.manual_select[0]] ? refsel_pkg::SEL_LOCKED
                  : refsel_pkg::SEL_UNLOCKED;
            end
            refsel_pkg::MODE_SHORT_HOLD: begin
               sel_q <= ctrl_q.manual_select[0];
               state_q <= valid_q[ctrl_q.manual_select[0]] ? refsel_pkg::SEL_LOCKED
                  : refsel_pkg::SEL_HOLDOVER;
            end
            refsel_pkg::MODE_AUTO: begin
               // a lost selection with no valid alternative stays put, unlocked
               if (sel_loss && !valid_q[!sel_q]) begin
                  state_q <= refsel_pkg::SEL_UNLOCKED;
               end else if (sel_loss) begin
                  sel_q <= !sel_q;
                  state_q <= refsel_pkg::SEL_LOCKED;
               end else if (state_q == refsel_pkg::SEL_UNLOCKED) begin
                  sel_q <= prio_pick;
                  state_q <= refsel_pkg::SEL_LOCKED;
               end else if (ctrl_q.revertive_enable && valid_q[!sel_q] && oth_prio > sel_prio) begin
                  sel_q <= !sel_q;
               end
            end
            refsel_pkg::MODE_AUTO_HOLD: begin
               if (state_q != refsel_pkg::SEL_HOLDOVER) begin
                  if (sel_loss) begin
                     state_q <= refsel_pkg::SEL_HOLDOVER;
                  end else if (ctrl_q.revertive_enable && valid_q[!sel_q]
                               && oth_prio > sel_prio) begin
                     sel_q <= !sel_q;
                  end
               end else if (hold_expire) begin
                  if (valid_q[sel_q]) begin
                     state_q <= refsel_pkg::SEL_LOCKED;
                  end else if (any_valid) begin
                     sel_q <= prio_pick;
                     state_q <= refsel_pkg::SEL_LOCKED;
                  end
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // holdover value and outputs
   // ----------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         held_word_q <= 32'h0000_0000;
         o_phase_word <= 32'h0000_0000;
      end else if (state_q == refsel_pkg::SEL_HOLDOVER) begin
         o_phase_word <= held_word_q;
      end else begin
         held_word_q <= i_phase_word;
         o_phase_word <= i_phase_word;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_active_select <= 1'b0;
         o_holdover <= 1'b0;
         o_reference_ok <= 1'b0;
      end else begin
         o_active_select <= sel_q;
         o_holdover <= (state_q == refsel_pkg::SEL_HOLDOVER);
         o_reference_ok <= (state_q == refsel_pkg::SEL_LOCKED) && valid_q[sel_q];
      end
   end

   // ----------------------------------------
   // sticky loss flags
   // ----------------------------------------
   logic wr_fire;
   logic [7:0] wr_addr_q;
   logic [31:0] wr_data_q;
   logic aw_got_q, w_got_q;
   logic sticky_wr;
   assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
   assign sticky_wr = wr_fire && wr_addr_q == refsel_pkg::STICKY_OFFSET;

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         sticky_input_q <= 2'h0;
         sticky_ref_q <= 1'b0;
         loss_armed_q <= 2'h3;
      end else begin
         for (int k = 0; k < 2; k++) begin
            // a set flag is disarmed, so a clear wins over a loss in the same cycle
            if (loss_event[k] && loss_armed_q[k] && !ctrl_q.loss_report_block) begin
               sticky_input_q[k] <= 1'b1;
               loss_armed_q[k] <= 1'b0;
            end else if (sticky_wr && wr_data_q[refsel_pkg::STICKY_INPUT_POS + k]) begin
               sticky_input_q[k] <= 1'b0;
               loss_armed_q[k] <= 1'b1;
            end
         end
         if (loss_event[sel_q] && !ctrl_q.loss_report_block) begin
            sticky_ref_q <= 1'b1;
         end else if (sticky_wr && wr_data_q[refsel_pkg::STICKY_REF_POS] && any_valid) begin
            sticky_ref_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // axi4-lite slave
   // ----------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         wr_addr_q <= 8'h00;
         wr_data_q <= 32'h0000_0000;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= refsel_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_got_q && s_axi_awvalid && !s_axi_awready;
         s_axi_wready <= !w_got_q && s_axi_wvalid && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            // high address bits fold to an unmapped offset; the answer never rereads the bus
            wr_addr_q <= (s_axi_awaddr[31:8] == 24'h00_0000) ? s_axi_awaddr[7:0] : 8'hFF;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wr_data_q <= s_axi_wdata;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_addr_q <= refsel_pkg::STICKY_OFFSET && wr_addr_q[1:0] == 2'h0)
               ? refsel_pkg::RESP_OKAY : refsel_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
         end
      end
   end

   // writes take every byte lane where fields live; wstrb is not used
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         ctrl_q <= refsel_pkg::ctrl_t'(refsel_pkg::CTRL_RESET);
         mon_div_q <= refsel_pkg::MON_DIV_RESET;
         revalidation_count_q <= refsel_pkg::REVALIDATION_COUNT_RESET;
         hold_start_q <= refsel_pkg::HOLD_START_RESET;
         hold_prescale_q <= refsel_pkg::HOLD_PRESCALE_RESET;
      end else if (wr_fire) begin
         unique case (wr_addr_q)
            refsel_pkg::CTRL_OFFSET: begin
               ctrl_q <= refsel_pkg::ctrl_t'(wr_data_q[11:0]);
            end
            refsel_pkg::MONITOR_OFFSET: begin
               mon_div_q <= wr_data_q[refsel_pkg::MON_DIV_POS +: 9];
               revalidation_count_q <= wr_data_q[refsel_pkg::MON_REVALIDATION_COUNT_POS +: 8];
            end
            refsel_pkg::HOLDOFF_OFFSET: begin
               hold_start_q <= wr_data_q[refsel_pkg::HOLD_START_POS +: 8];
               hold_prescale_q <= wr_data_q[refsel_pkg::HOLD_PRESCALE_POS +: 24];
            end
            default: begin
            end
         endcase
      end
   end

   logic [31:0] rd_word;
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (s_axi_araddr[7:0])
         refsel_pkg::CTRL_OFFSET: rd_word[11:0] = ctrl_q;
         refsel_pkg::MONITOR_OFFSET: begin
            rd_word[refsel_pkg::MON_DIV_POS +: 9] = mon_div_q;
            rd_word[refsel_pkg::MON_REVALIDATION_COUNT_POS +: 8] = revalidation_count_q;
         end
         refsel_pkg::HOLDOFF_OFFSET: begin
            rd_word[refsel_pkg::HOLD_START_POS +: 8] = hold_start_q;
            rd_word[refsel_pkg::HOLD_PRESCALE_POS +: 24] = hold_prescale_q;
         end
         refsel_pkg::STATUS_OFFSET: begin
            rd_word[refsel_pkg::STAT_VALID_POS +: 2] = valid_q;
            rd_word[refsel_pkg::STAT_SEL_POS] = sel_q;
            rd_word[refsel_pkg::STAT_REF_POS] = (state_q == refsel_pkg::SEL_LOCKED);
            rd_word[refsel_pkg::STAT_HOLD_POS] = (state_q == refsel_pkg::SEL_HOLDOVER);
            rd_word[refsel_pkg::STAT_COUNT_POS +: 8] = hold_cnt_q;
         end
         refsel_pkg::STICKY_OFFSET: begin
            rd_word[refsel_pkg::STICKY_INPUT_POS +: 2] = sticky_input_q;
            rd_word[refsel_pkg::STICKY_REF_POS] = sticky_ref_q;
         end
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= refsel_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= (s_axi_araddr[31:8] == 24'h00_0000) ? rd_word : 32'h0000_0000;
            s_axi_rresp <= (s_axi_araddr[31:0] <= 32'(refsel_pkg::STICKY_OFFSET)
               && s_axi_araddr[1:0] == 2'h0) ? refsel_pkg::RESP_OKAY : refsel_pkg::RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

// [tb/ref_source_model.sv]
// clock sources facing the selector: two references, vco and vcxo
// assumes the bench switches each reference on and off at will
module ref_source_model (
   input wire logic [1:0] i_run,
   output logic [1:0] o_ref_clk,
   output logic o_vco_clk,
   output logic o_vcxo_clk
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      o_vco_clk = 1'b0;
      forever #20 o_vco_clk = ~o_vco_clk;
   end
   initial begin
      o_vcxo_clk = 1'b0;
      forever #30 o_vcxo_clk = ~o_vcxo_clk;
   end
   // a stopped source sits static low, the failure the monitor must see
   for (genvar g = 0; g < 2; g++) begin : g_src
      initial begin
         o_ref_clk[g] = 1'b0;
         #(7 + 50 * g);
         forever #200 o_ref_clk[g] = i_run[g] ? ~o_ref_clk[g] : 1'b0;
      end
   end
endmodule

// [tb/reference_input_selector_monitor.sv]
// port checker for the selector: bus answers, holdover behaviour
// assumes one clock domain and the synchronous reset of the block
module reference_input_selector_monitor (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic [31:0] i_phase_word,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic o_active_select,
   input wire logic o_holdover,
   input wire logic o_reference_ok,
   input wire logic [31:0] o_phase_word
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   sequence aw_take_s; s_axi_awvalid && s_axi_awready; endsequence
   sequence b_wait_s; ##[1:4] s_axi_bvalid; endsequence
   sequence hold_two_s; o_holdover && $past(o_holdover); endsequence
   hold_unlocked_a: assert property (o_holdover |-> !o_reference_ok)
      else $error("locked while in holdover");
   hold_word_a: assert property (hold_two_s |-> $stable(o_phase_word))
      else $error("holdover word moved");
   live_word_a: assert property (!o_holdover && !$past(o_holdover) && !$past(i_reset)
      |-> o_phase_word == $past(i_phase_word)) else $error("live word not passed");
   hold_select_a: assert property (hold_two_s |-> $stable(o_active_select))
      else $error("select moved in holdover");
   b_answer_a: assert property (aw_take_s |-> b_wait_s)
      else $error("write response late");
   b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");
   r_stand_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready held too long");
endmodule
bind reference_input_selector reference_input_selector_monitor u_mon (.*);

// [tb/test_reference_input_selector.sv]
// self-checking bench for the selector over axi4-lite
// assumes the source model drives the pins and the checker is bound
module test_reference_input_selector;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst, awv, wv, bre, arv, rre;
   logic [31:0] awa, wd, ara;
   logic [31:0] ph = 32'h0000_0000;
   logic [1:0] run;
   wire logic [1:0] refc, bresp, rresp;
   wire logic vco, vcxo, awr, wr, bv, arr, rv, sel, hold, ok;
   wire logic [31:0] rd, pho;
   int miscompares = 0;
   int n_checks = 0;
   ref_source_model u_src (.i_run(run), .o_ref_clk(refc), .o_vco_clk(vco), .o_vcxo_clk(vcxo));
   reference_input_selector u_dut (.i_sys_clk(clk), .i_reset(rst), .i_ref_clk(refc),
      .i_vco_clk(vco), .i_vcxo_clk(vcxo), .i_phase_word(ph), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre),
      .o_active_select(sel), .o_holdover(hold), .o_reference_ok(ok), .o_phase_word(pho));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // a moving word makes a frozen holdover value visible
   always @(posedge clk) ph <= ph + 32'h0000_0001;
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr_reg(logic [7:0] a, logic [31:0] d, logic [1:0] er);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      awa <= {24'h00_0000, a};
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge clk);
         if (!aw_done && awr === 1'b1) begin
            aw_done = 1'b1;
            awv <= 1'b0;
         end
         if (!w_done && wr === 1'b1) begin
            w_done = 1'b1;
            wv <= 1'b0;
         end
      end
      while (bv !== 1'b1) @(posedge clk);
      bre <= 1'b0;
      check("bresp", {30'h0, bresp}, {30'h0, er});
      @(posedge clk);
   endtask
   task automatic rd_chk(string what, logic [7:0] a, logic [31:0] m, logic [31:0] e,
                         logic [1:0] er);
      ara <= {24'h00_0000, a};
      arv <= 1'b1;
      rre <= 1'b1;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 1'b0;
      while (rv !== 1'b1) @(posedge clk);
      rre <= 1'b0;
      check(what, rd & m, e);
      check("rresp", {30'h0, rresp}, {30'h0, er});
      @(posedge clk);
   endtask
   task automatic expect_out(string what, logic [2:0] e, int lim);
      for (int i = 0; i < lim && {sel, hold, ok} !== e; i++) @(posedge clk);
      check(what, {29'h0, sel, hold, ok}, {29'h0, e});
   endtask
   task automatic t_regs;
      rd_chk("ctrl", refsel_pkg::CTRL_OFFSET, 32'h0000_0FFF, 32'h0000_00F0, 2'h0);
      rd_chk("mon", refsel_pkg::MONITOR_OFFSET, 32'h00FF_01FF, 32'h0008_000A, 2'h0);
      rd_chk("hold", refsel_pkg::HOLDOFF_OFFSET, 32'hFFFF_FFFF, 32'h0010_00FF, 2'h0);
      rd_chk("unmapped", 8'h14, 32'hFFFF_FFFF, 32'h0000_0000, refsel_pkg::RESP_SLVERR);
      wr_reg(8'h14, 32'hFFFF_FFFF, refsel_pkg::RESP_SLVERR);
      $display("test regs done");
   endtask
   task automatic t_auto;
      wr_reg(refsel_pkg::CTRL_OFFSET, 32'h0000_00F1, 2'h0);
      run <= 2'b11;
      expect_out("auto lock", 3'b001, 3000);
      run <= 2'b10;
      expect_out("failover", 3'b101, 1000);
      rd_chk("sticky0", refsel_pkg::STICKY_OFFSET, 32'h1, 32'h1, 2'h0);
      run <= 2'b00;
      expect_out("no input", 3'b100, 1000);
      $display("test auto done");
   endtask
   task automatic t_hold;
      wr_reg(refsel_pkg::HOLDOFF_OFFSET, 32'h0000_0203, 2'h0);
      wr_reg(refsel_pkg::CTRL_OFFSET, 32'h0000_0033, 2'h0);
      run <= 2'b10;
      expect_out("relock", 3'b101, 3000);
      run <= 2'b11;
      repeat (800) @(posedge clk);
      rd_chk("valid", refsel_pkg::STATUS_OFFSET, 32'h3, 32'h3, 2'h0);
      run <= 2'b01;
      expect_out("holdover", 3'b110, 1000);
      expect_out("expiry", 3'b001, 300);
      rd_chk("reload", refsel_pkg::STATUS_OFFSET, 32'hFF00, 32'h0300, 2'h0);
      $display("test hold done");
   endtask
   task automatic t_block;
      wr_reg(refsel_pkg::STICKY_OFFSET, 32'h0000_0002, 2'h0);
      rd_chk("clear", refsel_pkg::STICKY_OFFSET, 32'h2, 32'h0, 2'h0);
      wr_reg(refsel_pkg::CTRL_OFFSET, 32'h0000_0200, 2'h0);
      run <= 2'b11;
      expect_out("manual", 3'b001, 3000);
      repeat (800) @(posedge clk);
      wr_reg(refsel_pkg::STICKY_OFFSET, 32'h0000_0003, 2'h0);
      run <= 2'b01;
      repeat (800) @(posedge clk);
      rd_chk("blocked", refsel_pkg::STICKY_OFFSET, 32'h2, 32'h0, 2'h0);
      wr_reg(refsel_pkg::CTRL_OFFSET, 32'h0000_0206, 2'h0);
      expect_out("short hold", 3'b110, 100);
      run <= 2'b11;
      expect_out("short relock", 3'b101, 3000);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      expect_out("reset", 3'b000, 1);
      $display("test block done");
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      miscompares++;
      finish_test;
   end
   initial begin
      {rst, awv, wv, bre, arv, rre} = 6'h3F & 6'h20;
      {awa, wd, ara} = {3{32'h0000_0000}};
      run = 2'b00;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs;
      t_auto;
      t_hold;
      t_block;
      finish_test;
   end
endmodule
